/* logic/coam_core.sv */
// Operand and address generation of an 8-bit Harvard core: six addressing modes
//
// Notes on behaviour
// - Program counter bits 15..8 readable as own byte, zero after reset.
// - Program counter bits 7..0 readable as own byte, zero after reset.
// - Source immediate: opcode picks accumulator, flags, stack pointer or index.
// - Source immediate: first operand byte is the immediate source.
// - Source immediate arithmetic: second source is the named register.
// - Source direct and indexed: result only to accumulator or index.
// - Source direct: first operand addresses RAM or register space source.
// - Source indexed: source address is first operand plus index.
// - Source direct/indexed arithmetic: second source is accumulator or index.
// - Destination direct: result to addressed location, source A or X.
// - Results written to memory leave the accumulator unchanged.
// - Destination indexed: address operand plus index, source only accumulator.
// - Destination indexed arithmetic: second source read at operand plus index.
// - Destination direct immediate: operand two is source, operand one address.
// - All modes two bytes long, destination direct immediate three bytes.
// - Register space is a separate space from RAM at the same address.
// - AND on flags with immediate gives old flags ANDed with immediate.
// - Bank bit in flags picks register bank 0 or 1 for register accesses.
//
// Chosen here: the strobed register port and the register addresses.
module coam_core
   import coam_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          rst_b,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [7:0]         reg_rdata,
   output coam_mem_req_t      mem_req,
   input  wire logic [7:0]    mem_rdata
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_EXEC
   } coam_state_t;

   coam_state_t   state_q,   state_d;
   coam_core_t    core_q,    core_d;
   coam_mem_req_t mem_q,     mem_d;
   logic [15:0]   pc_q,      pc_d;
   logic [7:0]    instr_q,   instr_d;
   logic [7:0]    opnd1_q,   opnd1_d;
   logic [7:0]    opnd2_q,   opnd2_d;
   logic          space_q,   space_d;
   logic [7:0]    fetched_q, fetched_d;
   logic [7:0]    rdata_q,   rdata_d;

   coam_mode_t    mode;
   coam_op_t      op;
   coam_sel_t     sel;
   logic [7:0]    eff_addr;
   logic          needs_read;
   logic          go;
   logic [15:0]   instr_len;

   // Instruction byte fields
   assign mode = coam_mode_t'(instr_q[IN_MODE_LSB +: $bits(coam_mode_t)]);
   assign op   = coam_op_t'(instr_q[IN_OP_LSB +: $bits(coam_op_t)]);
   assign sel  = coam_sel_t'(instr_q[IN_SEL_LSB +: $bits(coam_sel_t)]);
   // Start decode; the sequencer ignores it unless idle, so a repeated start is harmless
   assign go   = reg_wr && (reg_addr == OFS_GO);

   // Effective address; the sum is cut to eight bits so it wraps inside the page
   always_comb
   begin
      if (mode == MODE_SRC_IDX || mode == MODE_DST_IDX)
      begin
         eff_addr = 8'(opnd1_q + core_q.index);
      end
      else
      begin
         eff_addr = opnd1_q;
      end
   end

   // Memory-source modes always read; destination modes read only to combine
   always_comb
   begin
      unique case (mode)
         MODE_SRC_DIR, MODE_SRC_IDX: needs_read = 1'b1;
         MODE_DST_DIR, MODE_DST_IDX, MODE_DST_DIR_IMM:
            needs_read = (op != OP_MOV);
         default: needs_read = 1'b0;
      endcase
   end

   // Instruction length drives the program counter advance
   assign instr_len = (mode == MODE_DST_DIR_IMM) ? LEN_THREE : LEN_TWO;

   // Arithmetic/logic unit shared by all modes
   function automatic logic [8:0] coam_alu(
      input coam_op_t   f_op,
      input logic [7:0] src,
      input logic [7:0] second
   );
      logic [8:0] res;
      res = 9'h000;
      unique case (f_op)
         OP_ADD:  res = {1'b0, src} + {1'b0, second};
         OP_AND:  res = {1'b0, src & second};
         OP_OR:   res = {1'b0, src | second};
         OP_XOR:  res = {1'b0, src ^ second};
         default: res = {1'b0, src};
      endcase
      return res;
   endfunction : coam_alu

   // Register-selected value, used only as second source
   function automatic logic [7:0] coam_pick(
      input coam_core_t c,
      input coam_sel_t  s
   );
      logic [7:0] v;
      v = 8'h00;
      unique case (s)
         SEL_ACC:   v = c.acc;
         SEL_FLAGS: v = c.flags;
         SEL_STACK: v = c.stack;
         SEL_INDEX: v = c.index;
      endcase
      return v;
   endfunction : coam_pick

   // Sequencer next state, core registers and memory request
   always_comb
   begin
      logic [7:0] src;
      logic [7:0] second;
      logic [8:0] res;
      logic       to_mem;
      coam_sel_t  rsel;
      src       = 8'h00;
      second    = 8'h00;
      res       = 9'h000;
      to_mem    = 1'b0;
      rsel      = SEL_ACC;
      state_d   = state_q;
      core_d    = core_q;
      pc_d      = pc_q;
      fetched_d = fetched_q;
      mem_d     = '0;
      // Bank and space carried on every access so register space never aliases RAM
      mem_d.reg_space = space_q;
      mem_d.bank      = space_q & core_q.flags[F_BANK];
      mem_d.addr      = eff_addr;

      unique case (state_q)
         ST_IDLE:
         begin
            // A destination move needs no read, so it goes straight to execute
            if (go)
            begin
               if (needs_read)
               begin
                  mem_d.rd = 1'b1;
                  state_d  = ST_FETCH;
               end
               else
               begin
                  state_d = ST_EXEC;
               end
            end
         end
         ST_FETCH:
         begin
            // Read data stands one cycle after the request flip-flop
            if (!mem_q.rd)
            begin
               fetched_d = mem_rdata;
               state_d   = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            unique case (mode)
               MODE_SRC_IMM:
               begin
                  // Immediate byte combined with the register the opcode names
                  rsel   = sel;
                  src    = opnd1_q;
                  second = coam_pick(core_q, sel);
               end
               MODE_SRC_DIR, MODE_SRC_IDX:
               begin
                  // Fetched byte lands in A or X only; other selections fall back to A
                  rsel   = (sel == SEL_INDEX) ? SEL_INDEX : SEL_ACC;
                  src    = fetched_q;
                  second = coam_pick(core_q, rsel);
               end
               MODE_DST_DIR:
               begin
                  // Result goes back to the location the first operand addresses
                  to_mem = 1'b1;
                  src    = (sel == SEL_INDEX) ? core_q.index : core_q.acc;
                  second = fetched_q;
               end
               MODE_DST_IDX:
               begin
                  // Only the accumulator can feed an indexed destination
                  to_mem = 1'b1;
                  src    = core_q.acc;
                  second = fetched_q;
               end
               default:
               begin
                  // Immediate into a direct location; illegal mode codes end here too
                  to_mem = 1'b1;
                  src    = opnd2_q;
                  second = fetched_q;
               end
            endcase
            // One shared ALU; its carry bit only matters for additions
            res = coam_alu(op, src, second);

            if (to_mem)
            begin
               // Accumulator left alone when the result goes to a location
               mem_d.wr    = 1'b1;
               mem_d.wdata = res[7:0];
            end
            else
            begin
               unique case (rsel)
                  SEL_ACC:   core_d.acc   = res[7:0];
                  SEL_INDEX: core_d.index = res[7:0];
                  SEL_STACK: core_d.stack = res[7:0];
                  SEL_FLAGS:
                     // Supervisory and reserved bits stay as they are
                     core_d.flags = (core_q.flags & ~F_WMASK) | (res[7:0] & F_WMASK);
               endcase
            end

            // Zero follows arithmetic/logic and carry only additions, unless flags were the target
            if (op != OP_MOV && !(rsel == SEL_FLAGS && !to_mem))
            begin
               core_d.flags[F_ZERO] = (res[7:0] == 8'h00);
               if (op == OP_ADD)
               begin
                  core_d.flags[F_CARRY] = res[8];
               end
            end
            pc_d    = 16'(pc_q + instr_len);
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase

      // Software may preload the core registers only while idle
      if (reg_wr && state_q == ST_IDLE)
      begin
         unique case (reg_addr)
            OFS_ACC:   core_d.acc   = reg_wdata;
            OFS_INDEX: core_d.index = reg_wdata;
            OFS_STACK: core_d.stack = reg_wdata;
            OFS_FLAGS: core_d.flags = (core_q.flags & ~F_WMASK) | (reg_wdata & F_WMASK);
            default:   ;
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         state_q       <= ST_IDLE;
         core_q.acc    <= RST_BYTE;
         core_q.index  <= RST_BYTE;
         core_q.stack  <= RST_BYTE;
         core_q.flags  <= RST_FLAGS;
         pc_q          <= RST_PC;
         mem_q         <= '0;
         fetched_q     <= RST_BYTE;
      end
      else
      begin
         state_q   <= state_d;
         core_q    <= core_d;
         pc_q      <= pc_d;
         mem_q     <= mem_d;
         fetched_q <= fetched_d;
      end
   end

   // Memory request leaves straight from flip-flops, never from decode logic
   assign mem_req = mem_q;

   // Instruction staging registers; held while a sequence runs
   always_comb
   begin
      instr_d = instr_q;
      opnd1_d = opnd1_q;
      opnd2_d = opnd2_q;
      space_d = space_q;
      if (reg_wr && state_q == ST_IDLE)
      begin
         unique case (reg_addr)
            OFS_INSTR: instr_d = reg_wdata;
            OFS_OPND1: opnd1_d = reg_wdata;
            OFS_OPND2: opnd2_d = reg_wdata;
            OFS_CFG:   space_d = reg_wdata[CFG_SPACE];
            default:   ;
         endcase
      end
   end

   // Staging flip-flops
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         instr_q <= RST_BYTE;
         opnd1_q <= RST_BYTE;
         opnd2_q <= RST_BYTE;
         space_q <= 1'b0;
      end
      else
      begin
         instr_q <= instr_d;
         opnd1_q <= opnd1_d;
         opnd2_q <= opnd2_d;
         space_q <= space_d;
      end
   end

   // Read mux; data stands the cycle after the strobe, zero otherwise
   always_comb
   begin
      rdata_d = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            OFS_PC_HIGH: rdata_d = pc_q[15:8];
            OFS_PC_LOW:  rdata_d = pc_q[7:0];
            OFS_CFG:     rdata_d[CFG_SPACE] = space_q;
            OFS_INSTR:   rdata_d = instr_q;
            OFS_OPND1:   rdata_d = opnd1_q;
            OFS_OPND2:   rdata_d = opnd2_q;
            OFS_ACC:     rdata_d = core_q.acc;
            OFS_INDEX:   rdata_d = core_q.index;
            OFS_STACK:   rdata_d = core_q.stack;
            OFS_FLAGS:   rdata_d = core_q.flags;
            OFS_STATUS:
            begin
               // Busy while a sequence runs; length bit follows the loaded mode
               rdata_d[ST_BUSY] = (state_q != ST_IDLE);
               rdata_d[ST_LEN3] = (mode == MODE_DST_DIR_IMM);
            end
            default:     rdata_d = 8'h00;
         endcase
      end
   end

   // Read data flip-flop; zero between reads so a stale byte never looks valid
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         rdata_q <= RST_BYTE;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // Register port read data
   assign reg_rdata = rdata_q;

endmodule : coam_core

/* logic/coam_pkg.sv */
// Package: constants, enumerations and carriers of the operand/address generator
package coam_pkg;

   // Data and address widths
   localparam int DW = 8;
   localparam int PCW = 16;

   // Register port map (8-bit index, 8-bit data)
   localparam logic [7:0] OFS_PC_HIGH = 8'h00;
   localparam logic [7:0] OFS_PC_LOW  = 8'h01;
   localparam logic [7:0] OFS_CFG     = 8'h02;
   localparam logic [7:0] OFS_INSTR   = 8'h03;
   localparam logic [7:0] OFS_OPND1   = 8'h04;
   localparam logic [7:0] OFS_OPND2   = 8'h05;
   localparam logic [7:0] OFS_ACC     = 8'h06;
   localparam logic [7:0] OFS_INDEX   = 8'h07;
   localparam logic [7:0] OFS_STACK   = 8'h08;
   localparam logic [7:0] OFS_FLAGS   = 8'h09;
   localparam logic [7:0] OFS_STATUS  = 8'h0A;
   localparam logic [7:0] OFS_GO      = 8'h0B;

   // Reset values
   localparam logic [7:0]   RST_BYTE  = 8'h00;
   localparam logic [7:0]   RST_FLAGS = 8'h02;
   localparam logic [15:0]  RST_PC    = 16'h0000;

   // Flag bit positions
   localparam int F_GIE   = 0;
   localparam int F_ZERO  = 1;
   localparam int F_CARRY = 2;
   localparam int F_SUPER = 3;
   localparam int F_BANK  = 4;
   // Writable flag bits: reserved [7:5] and supervisory bit stay untouched
   localparam logic [7:0] F_WMASK = 8'h17;

   // Instruction byte fields
   localparam int IN_MODE_LSB = 0;
   localparam int IN_OP_LSB   = 3;
   localparam int IN_SEL_LSB  = 6;

   // Instruction lengths in bytes
   localparam logic [15:0] LEN_TWO   = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;

   // Status bits
   localparam int ST_BUSY = 0;
   localparam int ST_LEN3 = 1;

   // Configuration bits
   localparam int CFG_SPACE = 0;

   // Addressing modes
   typedef enum logic [2:0] {
      MODE_SRC_IMM,
      MODE_SRC_DIR,
      MODE_SRC_IDX,
      MODE_DST_DIR,
      MODE_DST_IDX,
      MODE_DST_DIR_IMM
   } coam_mode_t;

   // Operations
   typedef enum logic [2:0] {
      OP_MOV,
      OP_ADD,
      OP_AND,
      OP_OR,
      OP_XOR
   } coam_op_t;

   // Register selection carried in the instruction byte
   typedef enum logic [1:0] {
      SEL_ACC,
      SEL_FLAGS,
      SEL_STACK,
      SEL_INDEX
   } coam_sel_t;

   // Request towards RAM / peripheral register space
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       reg_space;
      logic       bank;
      logic [7:0] addr;
      logic [7:0] wdata;
   } coam_mem_req_t;

   // Core register set
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] index;
      logic [7:0] stack;
      logic [7:0] flags;
   } coam_core_t;

endpackage : coam_pkg

/* test/coam_core_sva.sv */
// Checker: port-level timing of the operand and address generator
module coam_core_sva
   import coam_pkg::*;
(
   input wire logic          clock,
   input wire logic          rst_b,
   input wire logic [7:0]    reg_addr,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_rdata,
   input wire coam_mem_req_t mem_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic go;
   // Start request seen on the register port
   assign go = reg_wr && reg_addr == OFS_GO;
   property p_rst_clear;
      $rose(rst_b) |-> reg_rdata == 8'h00 && mem_req == '0;
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear");
   property p_rd_after_go;
      mem_req.rd |-> $past(go);
   endproperty
   a_rd_after_go: assert property (p_rd_after_go) else $error("read without start");
   property p_rd_pulse;
      mem_req.rd |-> !mem_req.wr ##1 !mem_req.rd;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
   property p_wr_cause;
      mem_req.wr |-> $past(go, 2) || $past(mem_req.rd, 3);
   endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("write out of step");
   property p_same_loc;
      mem_req.rd ##3 mem_req.wr |-> mem_req.addr == $past(mem_req.addr, 3)
         && mem_req.reg_space == $past(mem_req.reg_space, 3);
   endproperty
   a_same_loc: assert property (p_same_loc) else $error("write misses read place");
   property p_bank_ram;
      mem_req.bank |-> mem_req.reg_space;
   endproperty
   a_bank_ram: assert property (p_bank_ram) else $error("bank set on RAM access");
   property p_unmapped;
      reg_rd && reg_addr > OFS_GO |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_go_busy;
      go ##1 (go && mem_req.rd) |=> !mem_req.rd;
   endproperty
   a_go_busy: assert property (p_go_busy) else $error("start taken while busy");
endmodule : coam_core_sva

bind coam_core coam_core_sva i_coam_core_sva (.clock(clock), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .mem_req(mem_req));

/* test/coam_mem_model.sv */
// Partner model: RAM and two register-space banks behind the memory port
module coam_mem_model
   import coam_pkg::*;
(
   input  wire logic          clock,
   input  wire coam_mem_req_t mem_req,
   output logic [7:0]         mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [1024];
   logic [9:0] ix;
   // RAM, bank 0 and bank 1 are separate regions of one array
   assign ix = {mem_req.reg_space, mem_req.bank, mem_req.addr};
   initial mem_rdata = 8'hA5;
   // Data only in the cycle after a read; toggles otherwise so stale data never matches
   always @(posedge clock)
   begin
      if (mem_req.rd)
         mem_rdata <= mem[ix];
      else
         mem_rdata <= ~mem_rdata;
      if (mem_req.wr)
         mem[ix] <= mem_req.wdata;
   end
endmodule : coam_mem_model

/* test/test_coam_core.sv */
// Testbench: register-port stimulus, memory partner and queued result checks
`define CHK(o, e) begin cmp_count++; if ((o) !== (e)) begin bad_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, o, e); end end
module test_coam_core
   import coam_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_p = 1'b0, c;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mem_rdata;
   logic [7:0]  a, x, sp, f, m, ad, src, sec, res;
   logic [15:0] pc = 16'h0000;
   logic [19:0] exp_q [$];
   logic [19:0] exp_v;
   int          bad_count = 0, cmp_count = 0, cyc = 0;
   coam_mem_req_t mem_req;

   coam_core i_coam_core (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_req(mem_req), .mem_rdata(mem_rdata));
   coam_mem_model i_coam_mem_model (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

   always #5 clock = ~clock;

   task automatic report_and_stop();
      // A note never consumed means an expected write or read answer went missing
      if (exp_q.size() != 0)
         bad_count++;
      $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop

   // Monitor: every read answer or memory write takes the oldest note; also the hang limit
   always @(posedge clock)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         bad_count++;
         report_and_stop();
      end
      else
      begin
         // Note taken once, so a mismatch print cannot swallow a second one
         if (rd_p || mem_req.wr)
         begin
            exp_v = exp_q.pop_front();
            `CHK(rd_p ? {12'h000, reg_rdata} : 20'(mem_req), exp_v)
         end
         rd_p <= reg_rd;
      end
   end

   // Strobe held n cycles, then one idle cycle so no signal is set twice in a step
   task automatic wr(input logic [7:0] ad_i, input logic [7:0] d, input int n = 1);
      reg_addr  <= ad_i;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      repeat (n) @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask : wr

   task automatic rd(input logic [7:0] ad_i, input logic [7:0] e);
      exp_q.push_back({12'h000, e});
      reg_addr <= ad_i;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
   endtask : rd

   // One instruction: load, predict, start twice (second refused), read back
   task automatic run(input coam_mode_t md, input coam_op_t op, input coam_sel_t sl,
                      input logic [7:0] o1, input logic [7:0] o2, input logic rs);
      logic      dst, idx, bk;
      coam_sel_t dsel;
      if (sl == SEL_FLAGS && op == OP_ADD)
         op = OP_AND;
      a  = $urandom;
      x  = $urandom;
      sp = $urandom;
      f  = $urandom;
      wr(OFS_CFG, {7'h00, rs});
      wr(OFS_INSTR, {sl, op, md});
      wr(OFS_OPND1, o1);
      wr(OFS_OPND2, o2);
      wr(OFS_ACC, a);
      wr(OFS_INDEX, x);
      wr(OFS_STACK, sp);
      wr(OFS_FLAGS, f);
      f    = f & F_WMASK;
      dst  = md >= MODE_DST_DIR;
      idx  = md == MODE_SRC_IDX || md == MODE_DST_IDX;
      bk   = rs & f[F_BANK];
      ad   = o1 + (idx ? x : 8'h00);
      m    = i_coam_mem_model.mem[{rs, bk, ad}];
      dsel = md == MODE_SRC_IMM ? sl : sl == SEL_INDEX ? SEL_INDEX : SEL_ACC;
      src  = md == MODE_SRC_IMM ? o1 : !dst ? m :
             md == MODE_DST_DIR_IMM ? o2 :
             (md == MODE_DST_DIR && sl == SEL_INDEX) ? x : a;
      sec  = dst ? m : dsel == SEL_ACC ? a : dsel == SEL_FLAGS ? f :
             dsel == SEL_STACK ? sp : x;
      {c, res} = op == OP_ADD ? {1'b0, src} + {1'b0, sec} : {1'b0, op == OP_MOV ? src :
                 op == OP_AND ? src & sec : op == OP_OR ? src | sec : src ^ sec};
      if (op != OP_MOV)
         f[F_ZERO] = res == 8'h00;
      if (op == OP_ADD)
         f[F_CARRY] = c;
      if (dst)
         exp_q.push_back({2'b01, rs, bk, ad, res});
      else
         case (dsel)
            SEL_ACC:   a  = res;
            SEL_INDEX: x  = res;
            SEL_STACK: sp = res;
            default:   f  = res & F_WMASK;
         endcase
      pc += md == MODE_DST_DIR_IMM ? LEN_THREE : LEN_TWO;
      wr(OFS_GO, 8'h01, 2);
      repeat (4) @(posedge clock);
      rd(OFS_ACC, a);
      rd(OFS_INDEX, x);
      rd(OFS_STACK, sp);
      rd(OFS_FLAGS, f);
      rd(OFS_PC_HIGH, pc[15:8]);
      rd(OFS_PC_LOW, pc[7:0]);
      rd(OFS_STATUS, {6'h00, md == MODE_DST_DIR_IMM, 1'b0});
   endtask : run

   // Main sequence: reset values, read-only and unmapped places, then every mode
   initial
   begin
      void'($urandom(72));
      for (int i = 0; i < 1024; i++)
         i_coam_mem_model.mem[i] = $urandom;
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      rd(OFS_PC_HIGH, RST_PC[15:8]);
      rd(OFS_PC_LOW, RST_PC[7:0]);
      rd(OFS_FLAGS, RST_FLAGS);
      wr(OFS_PC_LOW, 8'h5A);
      rd(OFS_PC_LOW, RST_PC[7:0]);
      rd(8'h3C, 8'h00);
      run(MODE_SRC_IMM, OP_AND, SEL_FLAGS, $urandom, $urandom, 1'b1);
      for (int k = 0; k < 60; k++)
         run(coam_mode_t'(k % 6), coam_op_t'((k / 6) % 5), coam_sel_t'($urandom),
             $urandom, $urandom, $urandom);
      // Let the monitor see the last read answer before the verdict
      repeat (2) @(posedge clock);
      report_and_stop();
   end
endmodule : test_coam_core
